// ---- rtl/legacy_walk_pkg.sv ----
// Shared constants and types for the legacy page walker
package legacy_walk_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int VA_W  = 32;              // Virtual address width
    localparam int PA_W  = 52;              // Widest physical address
    localparam int ENT_W = 64;              // Widest table entry
    localparam int ATR_W = 8;               // Packed attribute vector

    // ------------------------------------------------------------------
    // Entry field positions
    // ------------------------------------------------------------------
    localparam int BIT_PRESENT   = 0;       // Present
    localparam int BIT_DIRTY     = 6;       // Dirty, top of low attrs
    localparam int BIT_LARGE     = 7;       // Large-page select
    localparam int BIT_AIDX_4K   = 7;       // Attribute index, 4K entry
    localparam int BIT_GLOBAL    = 8;       // Global
    localparam int BIT_AIDX_BIG  = 12;      // Attribute index, large
    localparam int HI4M_LSB      = 13;      // Physical bits 39..32 low
    localparam int HI4M_MSB      = 20;      // Physical bits 39..32 high
    localparam int BIT_NOEXEC    = 63;      // No-execute, wide entries

    // ------------------------------------------------------------------
    // Page geometry
    // ------------------------------------------------------------------
    localparam int SHIFT_4K   = 12;         // 4-Kbyte page / table
    localparam int SHIFT_2M   = 21;         // 2-Mbyte page
    localparam int SHIFT_4M   = 22;         // 4-Mbyte page
    localparam int SHIFT_PTR  = 5;          // Pointer table alignment
    localparam int HI4M_PA    = 32;         // First split physical bit
    localparam int PA4M_W     = 40;         // 4-Mbyte address width

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [PA_W-1:0]  ADDR_RST  = 52'h0;
    localparam logic [VA_W-1:0]  VA_RST    = 32'h0;
    localparam logic [ATR_W-1:0] ATTR_RST  = 8'h00;
    localparam logic             READY_RST = 1'b1;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PG_4K = 2'b00,
        PG_4M = 2'b01,
        PG_2M = 2'b10
    } page_size_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PTR  = 2'b01,
        ST_DIR  = 2'b10,
        ST_TBL  = 2'b11
    } walk_state_e;

endpackage

// ---- rtl/entry_if.sv ----
// Raw entry and its decoded fields between walker and decoder
`timescale 1ns/1ps
interface entry_if import legacy_walk_pkg::*; ();
    logic [ENT_W-1:0] raw;                  // Entry as fetched
    logic             pae;                  // Wide entry format
    logic             present;              // Present bit
    logic             large_sel;            // Large-page select
    logic             aidx_4k;              // Attribute index, 4K
    logic             aidx_big;             // Attribute index, large
    logic             no_exec;              // No-execute
    logic [ATR_W-1:0] attr;                 // {g,d,a,cd,wt,us,rw,p}
    logic [PA_W-1:0]  tbl_base;             // Next-level / 4K base
    logic [PA_W-1:0]  big_base;             // Large page base

    modport dec  (input  raw, pae,
                  output present, large_sel, aidx_4k, aidx_big, no_exec,
                         attr, tbl_base, big_base);
    modport walk (output raw, pae,
                  input  present, large_sel, aidx_4k, aidx_big, no_exec,
                         attr, tbl_base, big_base);
endinterface

// ---- rtl/entry_decode.sv ----
// Field decoder for 32-bit and 64-bit translation entries
`timescale 1ns/1ps
module entry_decode import legacy_walk_pkg::*; (
    // Entry in, fields out
    entry_if.dec ent
);

    // ------------------------------------------------------------------
    // Format select
    // ------------------------------------------------------------------
    // Narrow entries only own the low word; the upper half of the bus
    // is forced to zero so stale data cannot leak into a base
    wire [ENT_W-1:0] w_ent = ent.pae ? ent.raw : {32'h0, ent.raw[31:0]};

    // ------------------------------------------------------------------
    // Flag fields
    // ------------------------------------------------------------------
    assign ent.present   = w_ent[BIT_PRESENT];
    assign ent.large_sel = w_ent[BIT_LARGE];
    assign ent.aidx_4k   = w_ent[BIT_AIDX_4K];
    // Large entries keep the attribute index at 12
    assign ent.aidx_big  = w_ent[BIT_AIDX_BIG];
    assign ent.no_exec   = w_ent[BIT_NOEXEC];
    // Global at 8 and dirty..present at 6..0
    assign ent.attr      = {w_ent[BIT_GLOBAL], w_ent[BIT_DIRTY:0]};

    // ------------------------------------------------------------------
    // Base addresses
    // ------------------------------------------------------------------
    // Wide entries carry up to 52 physical bits
    assign ent.tbl_base = {w_ent[PA_W-1:SHIFT_4K], 12'h000};
    // Split 4M field: 20..13 -> 39..32, 31..22 -> 31..22
    assign ent.big_base = ent.pae
        ? {w_ent[PA_W-1:SHIFT_2M], 21'h0}
        : {12'h000, w_ent[HI4M_MSB:HI4M_LSB],
           w_ent[VA_W-1:SHIFT_4M], 22'h0};

endmodule

// ---- rtl/legacy_page_walk_decode.sv ----
// Legacy-mode page-table walker: address split, fetch and entry decode
`timescale 1ns/1ps
module legacy_page_walk_decode import legacy_walk_pkg::*; (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Paging controls
    input  wire logic              page_size_ext_enable,
    input  wire logic              phys_addr_ext_enable,
    input  wire logic [VA_W-1:0]   translation_root_register,
    // Translation request
    input  wire logic              req_valid,
    input  wire logic [VA_W-1:0]   req_vaddr,
    output logic                   req_ready,
    // Entry fetch port to memory
    output logic                   mem_rd_req,
    output logic [PA_W-1:0]        mem_rd_addr,
    output logic                   mem_rd_wide,
    input  wire logic              mem_rd_valid,
    input  wire logic [ENT_W-1:0]  mem_rd_data,
    // Translation result
    output logic                   done,
    output logic [PA_W-1:0]        paddr,
    output logic [1:0]             page_size,
    output logic                   present,
    output logic [ATR_W-1:0]       attr,
    output logic                   attr_idx,
    output logic                   no_exec
);

    // ------------------------------------------------------------------
    // Fetch address arithmetic
    // ------------------------------------------------------------------
    // Entries are 4 bytes narrow, 8 bytes wide
    function automatic logic [PA_W-1:0] fetch_addr(
        input logic [PA_W-1:0] base,
        input logic [9:0]      idx,
        input logic            wide
    );
        logic [PA_W-1:0] off;
        off = wide ? {39'h0, idx, 3'h0} : {40'h0, idx, 2'h0};
        fetch_addr = base + off;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    walk_state_e       state_ff, nxt_state;   // Walk phase
    logic [VA_W-1:0]   va_ff, nxt_va;         // Address being walked
    logic [VA_W-1:0]   root_ff, nxt_root;     // Root captured at start
    logic              pae_ff, nxt_pae;       // Extended mode for walk
    logic              pse_on_ff, nxt_pse_on; // 4M allowed for walk
    logic              ready_ff, nxt_ready;   // Idle, can accept
    logic              req_ff, nxt_req;       // Fetch outstanding
    logic [PA_W-1:0]   addr_ff, nxt_addr;     // Fetch address
    logic              done_ff, nxt_done;     // Result pulse
    logic [PA_W-1:0]   paddr_ff, nxt_paddr;   // Physical address
    page_size_e        size_ff, nxt_size;     // Page size of result
    logic              present_ff, nxt_present;
    logic [ATR_W-1:0]  attr_ff, nxt_attr;
    logic              aidx_ff, nxt_aidx;     // Attribute index bit
    logic              noex_ff, nxt_noex;     // No-execute bit
    logic              fin;                   // Walk ends this cycle
    logic              fin_large;             // ... on a large page

    // ------------------------------------------------------------------
    // Entry decoder
    // ------------------------------------------------------------------
    entry_if ent ();
    assign ent.raw = mem_rd_data;
    assign ent.pae = pae_ff;

    entry_decode u_dec (
        .ent (ent)
    );

    // ------------------------------------------------------------------
    // Address selection
    // ------------------------------------------------------------------
    // Narrow root: base bits 31..12, low 12 zero
    wire [PA_W-1:0] dir_root_base =
        {20'h0, translation_root_register[VA_W-1:SHIFT_4K], 12'h000};
    // Wide root: base bits 31..5, 32-byte aligned
    wire [PA_W-1:0] ptr_root_base =
        {20'h0, translation_root_register[VA_W-1:SHIFT_PTR], 5'h00};
    // First fetch: directory by 31..22 or pointer by 31..30
    wire [PA_W-1:0] dir_root_addr =
        fetch_addr(dir_root_base, req_vaddr[31:22], 1'b0);
    wire [PA_W-1:0] ptr_root_addr =
        fetch_addr(ptr_root_base, {8'h0, req_vaddr[31:30]}, 1'b1);
    // Directory of wide walk indexed by 29..21
    wire [PA_W-1:0] dir_next_addr =
        fetch_addr(ent.tbl_base, {1'b0, va_ff[29:21]}, 1'b1);
    // Table index is 9 bits wide for 512 entries, else 10
    wire [9:0]      tbl_idx = pae_ff ? {1'b0, va_ff[20:12]}
                                     : va_ff[21:12];
    wire [PA_W-1:0] tbl_next_addr =
        fetch_addr(ent.tbl_base, tbl_idx, pae_ff);
    // Large bit honoured in wide mode regardless of size-ext
    wire            dir_large = ent.large_sel & (pae_ff | pse_on_ff);
    // Large offset is 20..0 wide 21..0 narrow
    wire [PA_W-1:0] big_paddr = pae_ff
        ? {ent.big_base[PA_W-1:SHIFT_2M], va_ff[SHIFT_2M-1:0]}
        : {ent.big_base[PA_W-1:SHIFT_4M], va_ff[SHIFT_4M-1:0]};
    wire [PA_W-1:0] tbl_paddr =
        {ent.tbl_base[PA_W-1:SHIFT_4K], va_ff[SHIFT_4K-1:0]};

    // ------------------------------------------------------------------
    // Walk sequencing
    // ------------------------------------------------------------------
    // A not-present entry ends the walk at once; the result shows it
    // with present low and nothing further is fetched
    always_comb begin
        nxt_state   = state_ff;
        nxt_va      = va_ff;
        nxt_root    = root_ff;
        nxt_pae     = pae_ff;
        nxt_pse_on  = pse_on_ff;
        nxt_req     = req_ff;
        nxt_addr    = addr_ff;
        nxt_done    = 1'b0;
        nxt_paddr   = paddr_ff;
        nxt_size    = size_ff;
        nxt_present = present_ff;
        nxt_attr    = attr_ff;
        nxt_aidx    = aidx_ff;
        nxt_noex    = noex_ff;
        fin         = 1'b0;
        fin_large   = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                if (req_valid) begin
                    nxt_va     = req_vaddr;
                    nxt_root   = translation_root_register;
                    nxt_pae    = phys_addr_ext_enable;
                    // 4M only with size-ext on, phys-ext off
                    nxt_pse_on = page_size_ext_enable &
                                 ~phys_addr_ext_enable;
                    nxt_req    = 1'b1;
                    if (phys_addr_ext_enable) begin
                        nxt_addr  = ptr_root_addr;
                        nxt_state = ST_PTR;
                    end else begin
                        nxt_addr  = dir_root_addr;
                        nxt_state = ST_DIR;
                    end
                end
            end
            ST_PTR: begin
                if (mem_rd_valid) begin
                    if (!ent.present) begin
                        fin = 1'b1;
                    end else begin
                        nxt_addr  = dir_next_addr;
                        nxt_state = ST_DIR;
                    end
                end
            end
            ST_DIR: begin
                if (mem_rd_valid) begin
                    if (!ent.present) begin
                        fin = 1'b1;
                    end else if (dir_large) begin
                        // No table fetch for large pages
                        fin       = 1'b1;
                        fin_large = 1'b1;
                    end else begin
                        nxt_addr  = tbl_next_addr;
                        nxt_state = ST_TBL;
                    end
                end
            end
            ST_TBL: begin
                if (mem_rd_valid) begin
                    fin = 1'b1;
                end
            end
        endcase
        if (fin) begin
            nxt_req     = 1'b0;
            nxt_done    = 1'b1;
            nxt_state   = ST_IDLE;
            nxt_present = ent.present;
            nxt_attr    = ent.attr;
            nxt_noex    = ent.no_exec;
            nxt_aidx    = fin_large ? ent.aidx_big : ent.aidx_4k;
            nxt_paddr   = fin_large ? big_paddr : tbl_paddr;
            nxt_size    = !fin_large ? PG_4K : (pae_ff ? PG_2M : PG_4M);
        end
        nxt_ready = (nxt_state == ST_IDLE);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Walk control
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= ST_IDLE;
            va_ff     <= VA_RST;
            root_ff   <= VA_RST;
            pae_ff    <= 1'b0;
            pse_on_ff <= 1'b0;
            ready_ff  <= READY_RST;
            req_ff    <= 1'b0;
            addr_ff   <= ADDR_RST;
        end else begin
            state_ff  <= nxt_state;
            va_ff     <= nxt_va;
            root_ff   <= nxt_root;
            pae_ff    <= nxt_pae;
            pse_on_ff <= nxt_pse_on;
            ready_ff  <= nxt_ready;
            req_ff    <= nxt_req;
            addr_ff   <= nxt_addr;
        end
    end

    // Result, held until the next walk ends; done is a one-cycle pulse
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            done_ff    <= 1'b0;
            paddr_ff   <= ADDR_RST;
            size_ff    <= PG_4K;
            present_ff <= 1'b0;
            attr_ff    <= ATTR_RST;
            aidx_ff    <= 1'b0;
            noex_ff    <= 1'b0;
        end else begin
            done_ff    <= nxt_done;
            paddr_ff   <= nxt_paddr;
            size_ff    <= nxt_size;
            present_ff <= nxt_present;
            attr_ff    <= nxt_attr;
            aidx_ff    <= nxt_aidx;
            noex_ff    <= nxt_noex;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign req_ready   = ready_ff;
    assign mem_rd_req  = req_ff;
    assign mem_rd_addr = addr_ff;
    assign mem_rd_wide = pae_ff;
    assign done        = done_ff;
    assign paddr       = paddr_ff;
    assign page_size   = size_ff;
    assign present     = present_ff;
    assign attr        = attr_ff;
    assign attr_idx    = aidx_ff;
    assign no_exec     = noex_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    wire dir_hit = (state_ff == ST_DIR) && mem_rd_valid && ent.present;

    AST_PSE_GATE: assert property (
        done_ff && (size_ff == PG_4M) |-> pse_on_ff && !pae_ff)
        else $error("4M result without size-ext or with phys-ext");
    AST_NARROW_LARGE: assert property (
        dir_hit && !pae_ff && ent.large_sel && pse_on_ff
        |=> done_ff && (state_ff == ST_IDLE) && (size_ff == PG_4M))
        else $error("narrow large entry did not end the walk");
    AST_DIR_FETCH: assert property (
        req_ff && (state_ff == ST_DIR) && !pae_ff
        |-> addr_ff == {20'h0, root_ff[31:12], va_ff[31:22], 2'h0})
        else $error("narrow directory fetch address wrong");
    AST_4M_PADDR: assert property (
        dir_hit && !pae_ff && dir_large
        |=> paddr_ff[39:32] == $past(mem_rd_data[20:13])
            && paddr_ff[31:22] == $past(mem_rd_data[31:22])
            && paddr_ff[21:0] == va_ff[21:0]
            && paddr_ff[51:40] == 12'h000)
        else $error("4M physical address assembled wrong");
    AST_4M_ATTR: assert property (
        dir_hit && !pae_ff && dir_large
        |=> attr_ff == {$past(mem_rd_data[8]), $past(mem_rd_data[6:0])}
            && aidx_ff == $past(mem_rd_data[12]))
        else $error("4M entry flags decoded wrong");
    AST_PTR_FETCH: assert property (
        req_ff && (state_ff == ST_PTR)
        |-> addr_ff == {20'h0, root_ff[31:5], va_ff[31:30], 3'h0})
        else $error("pointer fetch address wrong");
    AST_WIDE_TBL: assert property (
        req_ff && (state_ff == ST_TBL) && pae_ff
        |-> addr_ff[11:0] == {va_ff[20:12], 3'h0})
        else $error("wide table fetch index wrong");
    AST_WIDE_LARGE: assert property (
        dir_hit && pae_ff && ent.large_sel
        |=> done_ff && (size_ff == PG_2M)
            && paddr_ff == {$past(mem_rd_data[51:21]), va_ff[20:0]})
        else $error("2M mapping not taken from directory entry");
    AST_WIDE_SMALL: assert property (
        dir_hit && pae_ff && !ent.large_sel |=> state_ff == ST_TBL)
        else $error("wide directory bit 7 clear did not fetch table");
    AST_REQ_HOLD: assert property (
        req_ff && !mem_rd_valid |=> req_ff && $stable(addr_ff))
        else $error("fetch request dropped or moved before answer");

endmodule

// ---- test/walk_mem_model.sv ----
// Behavioural memory that holds translation tables for the walker
`timescale 1ns/1ps
module walk_mem_model import legacy_walk_pkg::*; (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Entry fetch port
    input  wire logic             mem_rd_req,
    input  wire logic [PA_W-1:0]  mem_rd_addr,
    input  wire logic             mem_rd_wide,
    output logic                  mem_rd_valid,
    output logic [ENT_W-1:0]      mem_rd_data,
    // Idle edges before each answer
    input  wire logic [3:0]       lat
);
    logic [ENT_W-1:0] mem [logic [PA_W-1:0]];  // Sparse entry store
    logic [3:0]       cnt;                     // Wait counter
    logic [ENT_W-1:0] w;                       // Entry at the address

    // ------------------------------------------------------------------
    // Answer path
    // ------------------------------------------------------------------
    // Data churns between answers so a stale sample never looks right
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_rd_valid <= 1'b0;
            mem_rd_data  <= '0;
            cnt          <= '0;
        end else begin
            mem_rd_valid <= 1'b0;
            mem_rd_data  <= ~mem_rd_data;
            // The edge after an answer is skipped so the same request is not answered twice
            if (mem_rd_req && !mem_rd_valid) begin
                if (cnt >= lat) begin
                    w = mem.exists(mem_rd_addr) ? mem[mem_rd_addr] : '0;
                    mem_rd_valid <= 1'b1;
                    // Narrow fetch: upper half carries junk on purpose
                    mem_rd_data  <= mem_rd_wide ? w : {~w[31:0], w[31:0]};
                    cnt          <= '0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule

// ---- test/tb_legacy_page_walk_decode.sv ----
// Self-checking bench for the legacy page walker
`timescale 1ns/1ps
module tb_legacy_page_walk_decode import legacy_walk_pkg::*;;
    logic             mclk, rst_n, req_valid, req_ready;
    logic             page_size_ext_enable, phys_addr_ext_enable;
    logic [VA_W-1:0]  translation_root_register, req_vaddr;
    logic             mem_rd_req, mem_rd_wide, mem_rd_valid;
    logic             done, present, attr_idx, no_exec;
    logic [PA_W-1:0]  mem_rd_addr, paddr;
    logic [ENT_W-1:0] mem_rd_data;
    logic [1:0]       page_size;
    logic [ATR_W-1:0] attr;
    logic [3:0]       mem_lat;                 // Memory wait setting
    logic [PA_W-1:0]  fa[$];                   // Fetch addresses seen
    logic             fw[$];                   // Fetch widths seen
    int               err_total, tests_run, cycles;

    legacy_page_walk_decode i_dut (.mclk, .rst_n, .page_size_ext_enable,
        .phys_addr_ext_enable, .translation_root_register, .req_valid,
        .req_vaddr, .req_ready, .mem_rd_req, .mem_rd_addr, .mem_rd_wide,
        .mem_rd_valid, .mem_rd_data, .done, .paddr, .page_size,
        .present, .attr, .attr_idx, .no_exec);
    walk_mem_model i_mem (.mclk, .rst_n, .mem_rd_req, .mem_rd_addr,
        .mem_rd_wide, .mem_rd_valid, .mem_rd_data, .lat(mem_lat));

    // ------------------------------------------------------------------
    // Clock, fetch log and hang guard
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Each answered fetch is one table access of the walk
    always @(posedge mclk) begin
        if (mem_rd_req && mem_rd_valid) begin
            fa.push_back(mem_rd_addr);
            fw.push_back(mem_rd_wide);
        end
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            close_out();
        end
    end

    task automatic close_out();
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // One walk: request, wait for done, compare the fetch sequence
    task automatic run(input logic s, e, input logic [31:0] r, va,
                       input logic [51:0] a [3], input int n);
        int k;
        fa.delete();
        fw.delete();
        @(posedge mclk);
        page_size_ext_enable      <= s;
        phys_addr_ext_enable      <= e;
        translation_root_register <= r;
        req_vaddr                 <= va;
        req_valid                 <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        #1;
        // Busy from the edge that takes the request
        check(req_ready, 1'b0);
        k = 0;
        do begin
            @(posedge mclk);
            #1;
            k++;
        end while (done !== 1'b1 && k < 60);
        // A walk that hangs leaves done low and is counted here
        check(done, 1'b1);
        check(req_ready, 1'b1);
        check(fa.size(), n);
        for (int i = 0; i < n && i < fa.size(); i++) begin
            check(fa[i], a[i]);
            check(fw[i], e);
        end
    endtask

    // Narrow 4K: size-ext on with bit 7 clear, size-ext off with bit 7
    // set, then a directory entry that is not present
    task automatic narrow_4k();
        logic [31:0] r, va, d, t;
        logic [51:0] a0, a1;
        int          n;
        r  = 32'h0001_2abc;
        va = 32'h1234_5678;
        t  = 32'h0abc_d003;
        for (int c = 0; c < 3; c++) begin
            d  = c == 0 ? 32'h0003_4001 : c == 1 ? 32'h0003_4081
                                                 : 32'h0003_4080;
            n  = c < 2 ? 2 : 1;
            a0 = 52'({r[31:12], 12'h000}) + 52'(va[31:22]) * 4;
            a1 = 52'({d[31:12], 12'h000}) + 52'(va[21:12]) * 4;
            i_mem.mem[a0] = 64'(d);
            i_mem.mem[a1] = 64'(t);
            run(c == 0, 1'b0, r, va, '{a0, a1, '0}, n);
            if (c < 2) begin
                check(paddr, 52'({t[31:12], va[11:0]}));
            end
            check(present, c < 2);
            check(page_size, PG_4K);
        end
    endtask

    // Narrow 4M with split high base and every flag position
    task automatic narrow_4m();
        logic [31:0] r, va, e;
        logic [51:0] a0;
        r  = 32'h0001_2000;
        va = 32'h8765_4321;
        e  = {10'h2c0, 1'b0, 8'h5a, 1'b1, 3'b000, 9'h1e5};
        a0 = 52'({r[31:12], 12'h000}) + 52'(va[31:22]) * 4;
        i_mem.mem[a0] = 64'(e);
        run(1'b1, 1'b0, r, va, '{a0, '0, '0}, 1);
        check(paddr, 52'({e[20:13], e[31:22], va[21:0]}));
        check(page_size, PG_4M);
        check(attr, {e[8], e[6:0]});
        check(attr_idx, e[12]);
        check(present, 1'b1);
        check(no_exec, 1'b0);
    endtask

    // Wide walk, 4K or 2M, with the size-ext enable set the wrong way
    task automatic wide_walk(input logic big, input logic [3:0] lat);
        logic [31:0] r, va;
        logic [63:0] p, d, t;
        logic [51:0] a0, a1, a2, x;
        int          n;
        r  = 32'h0004_567f;
        va = big ? 32'h4aa1_2345 : 32'hc060_3abc;
        p  = 64'h0000_0012_3456_7001;
        d  = big ? 64'h0000_000f_ff20_1083 : 64'h8000_0009_8765_4003;
        t  = 64'h8000_000a_bcde_f005;
        a0 = 52'({r[31:5], 5'h00}) + 52'(va[31:30]) * 8;
        a1 = {p[51:12], 12'h000} + 52'(va[29:21]) * 8;
        a2 = {d[51:12], 12'h000} + 52'(va[20:12]) * 8;
        i_mem.mem[a0] = p;
        i_mem.mem[a1] = d;
        i_mem.mem[a2] = t;
        mem_lat <= lat;
        n = big ? 2 : 3;
        x = big ? {d[51:21], va[20:0]} : {t[51:12], va[11:0]};
        run(!big, 1'b1, r, va, '{a0, a1, a2}, n);
        check(paddr, x);
        check(page_size, big ? PG_2M : PG_4K);
        check(no_exec, big ? d[63] : t[63]);
        check(attr_idx, big ? d[12] : t[7]);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        page_size_ext_enable = 1'b0;
        phys_addr_ext_enable = 1'b0;
        translation_root_register = '0;
        req_vaddr = '0;
        mem_lat = 4'h0;
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        narrow_4k();
        narrow_4m();
        wide_walk(1'b0, 4'h0);
        wide_walk(1'b1, 4'h0);
        // Slow memory must not change the outcome
        wide_walk(1'b0, 4'h3);
        wide_walk(1'b1, 4'h2);
        close_out();
    end
endmodule
